/* File: shared/bid_params.svh */
// Purpose: Constants for the base integer decode and state block
// Assumes: Included by bare name; definitions only
// Notes:   Field slices are written as msb:lsb ranges
`ifndef BID_PARAMS_SVH
`define BID_PARAMS_SVH

// ****************************************
// Widths and counts
// ****************************************
`define BID_REGISTER_WIDTH        32
`define BID_NREGS       32
`define BID_REG_AW      5
`define BID_ALIGN_WORD  32
`define BID_ALIGN_HALF  16

// ****************************************
// Program counter values
// ****************************************
`define BID_RESET_PC    32'h0000_0000
`define BID_TRAP_VEC    32'h0000_0004
`define BID_INSTR_STEP  32'h0000_0004

// ****************************************
// Instruction fields
// ****************************************
`define BID_F_LEN       1:0
`define BID_F_OPC       6:0
`define BID_F_RD        11:7
`define BID_F_FN3       14:12
`define BID_F_FN3_IMM   14
`define BID_F_RSA       19:15
`define BID_F_RSB       24:20
`define BID_F_SIGN      31
`define BID_F_IMM_I     31:20
`define BID_F_IMM_S_HI  31:25
`define BID_F_U         31:12
`define BID_F_B11       7
`define BID_F_B_MID     30:25
`define BID_F_B_LO      11:8
`define BID_F_J_HI      19:12
`define BID_F_J11       20
`define BID_F_J_LO      30:21
`define BID_F_U_ZERO    11:0

// ****************************************
// Encodings
// ****************************************
`define BID_LEN32       2'h3
`define BID_OP_LUI      7'h37
`define BID_OP_AUIPC    7'h17
`define BID_OP_JAL      7'h6F
`define BID_OP_JALR     7'h67
`define BID_OP_BRANCH   7'h63
`define BID_OP_LOAD     7'h03
`define BID_OP_STORE    7'h23
`define BID_OP_OPIMM    7'h13
`define BID_OP_OP       7'h33
`define BID_OP_MEMORY_A    7'h0F
`define BID_OP_SYSTEM   7'h73
`define BID_FN3_PRIV    3'h0
`define BID_LINK_REG    5'h01
`define BID_ALT_LINK    5'h05
`define BID_ZERO_REG    5'h00

`endif

/* File: shared/bid_pkg.sv */
// Purpose: Types shared by the decode and state block
// Assumes: Register width is fixed at the base value here
// Notes:   Carriers are packed structs
package bid_pkg;

    typedef enum logic [2:0] {
        FMT_R, FMT_I, FMT_S, FMT_B, FMT_U, FMT_J, FMT_BAD
    } bid_fmt_t;

    typedef enum logic [1:0] {
        ST_FETCH, ST_ISSUE, ST_WAIT
    } bid_state_t;

    // Two little-endian parcels, low half at the lower address
    typedef struct packed {
        logic [15:0] parcel_hi;
        logic [15:0] parcel_lo;
    } bid_fetch_t;

    typedef struct packed {
        logic [31:0] pc;
        logic [31:0] instr;
        bid_fmt_t    fmt;
        logic [4:0]  source_reg_a;
        logic [4:0]  source_reg_b;
        logic [4:0]  rd;
        logic [31:0] imm;
        logic [31:0] opnd_a;
        logic [31:0] opnd_b;
        logic        illegal;
        logic        sys_trap;
        logic        memory_a_nop;
        logic        call_hint;
        logic        ret_hint;
    } bid_issue_t;

    typedef struct packed {
        logic        taken;
        logic [31:0] target;
        logic        wr_en;
        logic [4:0]  wr_rd;
        logic [31:0] wr_data;
    } bid_resolve_t;

    typedef struct packed {
        logic        valid;
        logic [31:0] pc;
        logic [31:0] target;
    } bid_exc_t;

endpackage

/* File: hdl/bid_regfile.sv */
// Purpose: General register file, two reads and one write
// Assumes: Write address and data come from the same clock domain
// Notes:   Entry zero is never written and always reads zero
`timescale 1ns/10ps
`include "bid_params.svh"

module bid_regfile #(
    parameter int W  = `BID_REGISTER_WIDTH,
    parameter int N  = `BID_NREGS,
    parameter int AW = `BID_REG_AW
) (
    // Clock and reset
    input  wire logic          clk_sys,
    input  wire logic          srst,
    // Read ports
    input  wire logic [AW-1:0] rd_addr_a,
    input  wire logic [AW-1:0] rd_addr_b,
    output logic      [W-1:0]  rd_data_a,
    output logic      [W-1:0]  rd_data_b,
    // Write port
    input  wire logic          wr_en,
    input  wire logic [AW-1:0] wr_addr,
    input  wire logic [W-1:0]  wr_data
);

    logic [W-1:0] mem_ff  [N];
    logic [W-1:0] nxt_mem [N];

    if (N != (1 << AW)) begin : g_bad_size
        $error("Register count must fill the address space");
    end

    // ****************************************
    // Storage
    // ****************************************
    for (genvar i = 0; i < N; i++) begin : g_entry
        always_comb begin
            if (srst) begin
                nxt_mem[i] = '0;
            end else if (i != 0 && wr_en && wr_addr == AW'(i)) begin
                nxt_mem[i] = wr_data;
            end else begin
                nxt_mem[i] = mem_ff[i];
            end
        end
        always_ff @(posedge clk_sys) begin
            mem_ff[i] <= nxt_mem[i];
        end
    end

    // ****************************************
    // Reads
    // ****************************************
    // Gate on the address too, so entry zero reads zero even before reset
    assign rd_data_a = (rd_addr_a == '0) ? '0 : mem_ff[rd_addr_a];
    assign rd_data_b = (rd_addr_b == '0) ? '0 : mem_ff[rd_addr_b];

    AST_WRITE_THEN_READ: assert property (@(posedge clk_sys) disable iff (srst)
        (wr_en && wr_addr != '0) ##1 (rd_addr_a == $past(wr_addr))
        |-> rd_data_a == $past(wr_data))
        else $error("Written register did not read back");

endmodule

/* File: hdl/bid_decode_state.sv */
// Purpose: Decode front end and architectural integer state
// Assumes: Fetch, issue and resolve partners share clk_sys
// Notes:   One instruction in flight; resolve closes each one
`timescale 1ns/10ps
`include "bid_params.svh"

module bid_decode_state #(
    parameter int          REG_WIDTH     = `BID_REGISTER_WIDTH,
    parameter bit          SHORT_EXT     = 1'b0,
    parameter bit          RESERVED_TRAP = 1'b1,
    parameter logic [31:0] RESET_PC      = `BID_RESET_PC,
    parameter logic [31:0] TRAP_VEC      = `BID_TRAP_VEC
) (
    // Clock and reset
    input  wire logic                  clk_sys,
    input  wire logic                  srst,
    // Fetch side
    input  wire logic                  fch_valid,
    input  wire bid_pkg::bid_fetch_t   fch_word,
    output logic                       fch_ready,
    output logic [31:0]                program_counter,
    // Issue side
    output logic                       iss_valid,
    output bid_pkg::bid_issue_t        iss_data,
    input  wire logic                  exe_ready,
    // Resolve side
    input  wire logic                  res_valid,
    input  wire bid_pkg::bid_resolve_t res_data,
    output logic                       res_ready,
    // Exception report
    output bid_pkg::bid_exc_t          exc_data
);

    localparam int INSTR_ALIGN = SHORT_EXT ? `BID_ALIGN_HALF : `BID_ALIGN_WORD;

    // ****************************************
    // Elaboration checks
    // ****************************************
    if (REG_WIDTH != `BID_REGISTER_WIDTH) begin : g_bad_width
        $error("Only the base register width is supported");
    end
    if (RESET_PC[0] || TRAP_VEC[0] ||
        (INSTR_ALIGN == `BID_ALIGN_WORD && (RESET_PC[1] || TRAP_VEC[1]))) begin : g_bad_vec
        $error("Start and trap addresses must meet the alignment");
    end

    // ****************************************
    // Declarations
    // ****************************************
    bid_pkg::bid_state_t  state_ff;
    bid_pkg::bid_state_t  nxt_state;
    logic [31:0]          pc_ff;
    logic [31:0]          nxt_pc;
    bid_pkg::bid_issue_t  iss_ff;
    bid_pkg::bid_issue_t  nxt_iss;
    bid_pkg::bid_exc_t    exc_ff;
    bid_pkg::bid_exc_t    nxt_exc;

    logic [31:0]          instr;
    logic [6:0]           opcode;
    logic [2:0]           funct3;
    logic [4:0]           spec_a;
    logic [4:0]           spec_b;
    logic [4:0]           spec_d;
    logic [31:0]          imm_i;
    logic [31:0]          imm_s;
    logic [31:0]          imm_b;
    logic [31:0]          imm_u;
    logic [31:0]          imm_j;
    logic [31:0]          imm_z;
    logic [31:0]          rf_data_a;
    logic [31:0]          rf_data_b;
    logic                 rf_wr_en;
    logic                 res_fire;
    logic                 res_mis;
    bid_pkg::bid_issue_t  dec;

    // ****************************************
    // Field extraction
    // ****************************************
    // Low parcel holds the low instruction bits whatever the data endianness
    assign instr  = {fch_word.parcel_hi, fch_word.parcel_lo};
    assign opcode = instr[`BID_F_OPC];
    assign funct3 = instr[`BID_F_FN3];
    assign spec_a = instr[`BID_F_RSA];
    assign spec_b = instr[`BID_F_RSB];
    assign spec_d = instr[`BID_F_RD];

    // Sign from bit 31 for all but the zero-extended imm_z, so extension runs beside opcode decode
    assign imm_i = 32'($signed(instr[`BID_F_IMM_I]));
    assign imm_s = 32'($signed({instr[`BID_F_IMM_S_HI], instr[`BID_F_RD]}));
    assign imm_b = 32'($signed({instr[`BID_F_SIGN], instr[`BID_F_B11],
                                instr[`BID_F_B_MID], instr[`BID_F_B_LO], 1'b0}));
    assign imm_u = {instr[`BID_F_U], 12'h000};
    assign imm_j = 32'($signed({instr[`BID_F_SIGN], instr[`BID_F_J_HI],
                                instr[`BID_F_J11], instr[`BID_F_J_LO], 1'b0}));
    assign imm_z = 32'(spec_a);

    // ****************************************
    // Register file
    // ****************************************
    bid_regfile #(
        .W  (REG_WIDTH),
        .N  (`BID_NREGS),
        .AW (`BID_REG_AW)
    ) bid_regfile_i (
        .clk_sys   (clk_sys),
        .srst      (srst),
        .rd_addr_a (spec_a),
        .rd_addr_b (spec_b),
        .rd_data_a (rf_data_a),
        .rd_data_b (rf_data_b),
        .wr_en     (rf_wr_en),
        .wr_addr   (res_data.wr_rd),
        .wr_data   (res_data.wr_data)
    );

    // ****************************************
    // Decode
    // ****************************************
    always_comb begin
        dec              = '0;
        dec.pc           = pc_ff;
        dec.instr        = instr;
        dec.source_reg_a = spec_a;
        dec.source_reg_b = spec_b;
        dec.rd           = spec_d;
        dec.opnd_a       = rf_data_a;
        dec.opnd_b       = rf_data_b;
        dec.fmt          = bid_pkg::FMT_BAD;
        case (opcode)
            `BID_OP_LUI, `BID_OP_AUIPC: begin
                dec.fmt = bid_pkg::FMT_U;
                dec.imm = imm_u;
            end
            `BID_OP_JAL: begin
                dec.fmt       = bid_pkg::FMT_J;
                dec.imm       = imm_j;
                dec.call_hint = (spec_d == `BID_LINK_REG) || (spec_d == `BID_ALT_LINK);
            end
            `BID_OP_JALR: begin
                dec.fmt       = bid_pkg::FMT_I;
                dec.imm       = imm_i;
                // Only a hint: any register still works as a link
                dec.call_hint = (spec_d == `BID_LINK_REG) || (spec_d == `BID_ALT_LINK);
                dec.ret_hint  = !dec.call_hint &&
                                ((spec_a == `BID_LINK_REG) || (spec_a == `BID_ALT_LINK));
            end
            `BID_OP_BRANCH: begin
                dec.fmt = bid_pkg::FMT_B;
                dec.imm = imm_b;
            end
            `BID_OP_LOAD, `BID_OP_OPIMM: begin
                dec.fmt = bid_pkg::FMT_I;
                dec.imm = imm_i;
            end
            `BID_OP_STORE: begin
                dec.fmt = bid_pkg::FMT_S;
                dec.imm = imm_s;
            end
            `BID_OP_OP: begin
                dec.fmt = bid_pkg::FMT_R;
            end
            `BID_OP_MEMORY_A: begin
                dec.fmt       = bid_pkg::FMT_I;
                dec.imm       = imm_i;
                dec.memory_a_nop = 1'b1;
            end
            `BID_OP_SYSTEM: begin
                dec.fmt = bid_pkg::FMT_I;
                if (funct3 == `BID_FN3_PRIV) begin
                    // Call and breakpoint fold into one always-trapping form
                    dec.imm      = imm_i;
                    dec.sys_trap = 1'b1;
                end else if (funct3[`BID_F_FN3_IMM - 12]) begin
                    dec.imm = imm_z;
                end else begin
                    dec.imm = imm_i;
                end
            end
            default: begin
                dec.illegal = RESERVED_TRAP;
            end
        endcase
        // Anything not 32 bits long is outside this base decoder
        if (instr[`BID_F_LEN] != `BID_LEN32) begin
            dec.fmt     = bid_pkg::FMT_BAD;
            dec.illegal = 1'b1;
        end
    end

    // ****************************************
    // Sequencing and program counter
    // ****************************************
    assign res_fire = (state_ff == bid_pkg::ST_WAIT) && res_valid;
    assign res_mis  = (INSTR_ALIGN == `BID_ALIGN_WORD) ? (res_data.target[1:0] != 2'h0)
                                                       : res_data.target[0];
    // A faulting jump must not leave its link value behind
    assign rf_wr_en = res_fire && res_data.wr_en && !(res_data.taken && res_mis);

    always_comb begin
        nxt_state = state_ff;
        nxt_pc    = pc_ff;
        nxt_iss   = iss_ff;
        nxt_exc   = '0;
        case (state_ff)
            bid_pkg::ST_FETCH: begin
                if (fch_valid) begin
                    nxt_iss   = dec;
                    nxt_state = bid_pkg::ST_ISSUE;
                end
            end
            bid_pkg::ST_ISSUE: begin
                if (exe_ready) begin
                    nxt_state = bid_pkg::ST_WAIT;
                end
            end
            bid_pkg::ST_WAIT: begin
                if (res_valid) begin
                    nxt_state = bid_pkg::ST_FETCH;
                    if (res_data.taken && res_mis) begin
                        nxt_exc.valid  = 1'b1;
                        nxt_exc.pc     = pc_ff;
                        nxt_exc.target = res_data.target;
                        nxt_pc         = TRAP_VEC;
                    end else if (res_data.taken) begin
                        nxt_pc = res_data.target;
                    end else begin
                        nxt_pc = pc_ff + `BID_INSTR_STEP;
                    end
                end
            end
            default: begin
                nxt_state = bid_pkg::ST_FETCH;
            end
        endcase
        if (srst) begin
            nxt_state = bid_pkg::ST_FETCH;
            nxt_pc    = RESET_PC;
            nxt_iss   = '0;
            nxt_exc   = '0;
        end
    end

    always_ff @(posedge clk_sys) begin
        state_ff <= nxt_state;
        pc_ff    <= nxt_pc;
        iss_ff   <= nxt_iss;
        exc_ff   <= nxt_exc;
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign fch_ready       = (state_ff == bid_pkg::ST_FETCH);
    assign iss_valid       = (state_ff == bid_pkg::ST_ISSUE);
    assign res_ready       = (state_ff == bid_pkg::ST_WAIT);
    assign program_counter = pc_ff;
    assign iss_data        = iss_ff;
    assign exc_data        = exc_ff;

    // ****************************************
    // Checks
    // ****************************************
    AST_ZERO_OPERAND: assert property (@(posedge clk_sys) disable iff (srst)
        (state_ff == bid_pkg::ST_FETCH && fch_valid && spec_a == `BID_ZERO_REG)
        |=> iss_ff.opnd_a == '0)
        else $error("Register zero read nonzero");

    AST_MISALIGN_ON_JUMP: assert property (@(posedge clk_sys) disable iff (srst)
        (res_fire && res_data.taken && res_mis)
        |=> exc_ff.valid && exc_ff.pc == $past(pc_ff) && pc_ff == TRAP_VEC ##1 !exc_ff.valid)
        else $error("Misaligned target not reported on the jump");

    AST_NOT_TAKEN_SILENT: assert property (@(posedge clk_sys) disable iff (srst)
        (res_fire && !res_data.taken)
        |=> !exc_ff.valid && pc_ff == $past(pc_ff) + `BID_INSTR_STEP)
        else $error("Untaken branch faulted or skipped");

    AST_PC_ALIGNED: assert property (@(posedge clk_sys) disable iff (srst)
        (INSTR_ALIGN == `BID_ALIGN_WORD) ? (pc_ff[1:0] == 2'h0) : !pc_ff[0])
        else $error("Program counter left its alignment");

    AST_SIGN_FROM_31: assert property (@(posedge clk_sys) disable iff (srst)
        iss_valid && (iss_ff.fmt inside {bid_pkg::FMT_S, bid_pkg::FMT_B, bid_pkg::FMT_J,
                                         bid_pkg::FMT_U})
        |-> iss_ff.imm[31] == iss_ff.instr[`BID_F_SIGN])
        else $error("Immediate sign not from bit 31");

    AST_FIXED_SPECS: assert property (@(posedge clk_sys) disable iff (srst)
        $rose(iss_valid) |-> iss_ff.rd == iss_ff.instr[`BID_F_RD] &&
        iss_ff.source_reg_a == iss_ff.instr[`BID_F_RSA] &&
        iss_ff.source_reg_b == iss_ff.instr[`BID_F_RSB] && iss_ff.pc == pc_ff)
        else $error("Register specifier taken from wrong bits");

    AST_LENGTH_CHECK: assert property (@(posedge clk_sys) disable iff (srst)
        iss_valid && iss_ff.instr[`BID_F_LEN] != `BID_LEN32
        |-> iss_ff.illegal && iss_ff.fmt == bid_pkg::FMT_BAD)
        else $error("Short encoding not flagged illegal");

    AST_UPPER_IMM: assert property (@(posedge clk_sys) disable iff (srst)
        iss_valid && iss_ff.fmt == bid_pkg::FMT_U
        |-> iss_ff.imm[`BID_F_U_ZERO] == 12'h000 && iss_ff.imm[31:12] == iss_ff.instr[`BID_F_U])
        else $error("Upper immediate malformed");

    AST_ISSUE_HOLDS: assert property (@(posedge clk_sys) disable iff (srst)
        iss_valid && !exe_ready |=> iss_valid && $stable(iss_ff) && $stable(pc_ff))
        else $error("Issue changed while stalled");

endmodule

/* File: test/bid_far_model.sv */
// Purpose: Fetch unit and execute pipeline facing the decode block
// Assumes: One instruction in flight, requests held until accepted
// Notes:   slow adds wait cycles before each answer
`timescale 1ns/10ps
module bid_far_model (
    // Clock, reset and bench control
    input  wire logic                  clk_sys,
    input  wire logic                  srst,
    input  wire logic                  go,
    input  wire logic                  slow,
    input  wire logic [31:0]           ins,
    input  wire bid_pkg::bid_resolve_t rin,
    // Design side
    output bid_pkg::bid_fetch_t        fch_word,
    output logic                       fch_valid,
    output logic                       exe_ready,
    output logic                       res_valid,
    output bid_pkg::bid_resolve_t      res_data,
    input  wire logic                  fch_ready,
    input  wire logic                  iss_valid,
    input  wire logic                  res_ready
);
    logic [3:0] dly;
    always @(posedge clk_sys) begin
        if (srst) begin
            fch_word  <= '0;
            res_data  <= '0;
            fch_valid <= 1'b0;
            exe_ready <= 1'b0;
            res_valid <= 1'b0;
            dly       <= 4'h0;
        end else begin
            if (go) begin
                fch_valid <= 1'b1;
                fch_word  <= '{ins[31:16], ins[15:0]};
            end else if (fch_valid && fch_ready) begin
                fch_valid <= 1'b0;
                // Released word is inverted so a stale value cannot pass
                fch_word  <= bid_pkg::bid_fetch_t'(~fch_word);
            end
            dly       <= ((iss_valid && !exe_ready) || (res_ready && !res_valid)) ? dly + 4'h1 : 4'h0;
            exe_ready <= !slow || (iss_valid && !exe_ready && dly >= 4'h2);
            if (res_valid && res_ready) begin
                res_valid <= 1'b0;
                res_data  <= bid_pkg::bid_resolve_t'(~res_data);
            end else if (res_ready && !res_valid && (!slow || dly >= 4'h2)) begin
                res_valid <= 1'b1;
                res_data  <= rin;
            end
        end
    end
endmodule

/* File: test/base_integer_decode_state_bench.sv */
// Purpose: Self-checking bench for the decode and state block
// Assumes: Default parameters, so alignment is one word
// Notes:   Each op carries one instruction through fetch, issue and resolve
`timescale 1ns/10ps
`include "bid_params.svh"
module base_integer_decode_state_bench;
    logic                  clk_sys = 1'b0;
    logic                  srst    = 1'b1;
    logic                  go      = 1'b0;
    logic                  slow    = 1'b0;
    logic [31:0]           ins     = 32'h0;
    bid_pkg::bid_resolve_t rin     = '0;
    logic                  fch_valid, fch_ready, iss_valid, exe_ready, res_valid, res_ready;
    logic [31:0]           program_counter, pc0;
    bid_pkg::bid_fetch_t   fch_word;
    bid_pkg::bid_issue_t   iss_data, cap;
    bid_pkg::bid_resolve_t res_data;
    bid_pkg::bid_exc_t     exc_data, xc;
    int                    n_mismatch   = 0;
    int                    total_checks = 0;
    always #2.5 clk_sys = ~clk_sys;
    bid_decode_state bid_decode_state_i (.clk_sys(clk_sys), .srst(srst), .fch_valid(fch_valid),
        .fch_word(fch_word), .fch_ready(fch_ready), .program_counter(program_counter),
        .iss_valid(iss_valid), .iss_data(iss_data), .exe_ready(exe_ready), .res_valid(res_valid),
        .res_data(res_data), .res_ready(res_ready), .exc_data(exc_data));
    bid_far_model bid_far_model_i (.clk_sys(clk_sys), .srst(srst), .go(go), .slow(slow), .ins(ins),
        .rin(rin), .fch_word(fch_word), .fch_valid(fch_valid), .exe_ready(exe_ready),
        .res_valid(res_valid), .res_data(res_data), .fch_ready(fch_ready), .iss_valid(iss_valid),
        .res_ready(res_ready));
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            n_mismatch++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Settle after the edge before looking
    task automatic step;
        @(posedge clk_sys);
        #1;
    endtask
    task automatic op(input logic [31:0] i, input logic t, input logic [31:0] tg, input logic we,
                      input logic [4:0] rd, input logic [31:0] wd);
        int k;
        pc0 = program_counter;
        @(posedge clk_sys);
        ins <= i;
        rin <= '{t, tg, we, rd, wd};
        go  <= 1'b1;
        @(posedge clk_sys);
        go <= 1'b0;
        for (k = 0; k < 40 && iss_valid !== 1'b1; k++) step();
        cap = iss_data;
        for (k = k; k < 40 && (res_ready & res_valid) !== 1'b1; k++) step();
        if (k >= 40) begin
            chk("handshake", 1, 0);
            end_of_test();
        end
        step();
        xc = exc_data;
        chk("ready_back", 1, fch_ready);
        step();
        chk("exc_one_cycle", 0, exc_data.valid);
    endtask
    task automatic t_fields;
        op(32'h00A483B3, 0, 0, 0, 0, 0);
        chk("rsa", 9, cap.source_reg_a);
        chk("rsb", 10, cap.source_reg_b);
        chk("rd", 7, cap.rd);
        chk("instr", 32'h00A483B3, cap.instr);
        chk("iss_pc", pc0, cap.pc);
        chk("pc_step", pc0 + `BID_INSTR_STEP, program_counter);
        op(32'hFFF00213, 0, 0, 0, 0, 0);
        chk("imm_i", 32'hFFFFFFFF, cap.imm);
        op(32'h800010B7, 0, 0, 0, 0, 0);
        chk("imm_u", 32'h80001000, cap.imm);
        chk("fmt_u", bid_pkg::FMT_U, cap.fmt);
        op(32'h800FD073, 0, 0, 0, 0, 0);
        chk("imm_csr", 32'h0000001F, cap.imm);
        op(32'h80000FA3, 0, 0, 0, 0, 0);
        chk("imm_s", 32'hFFFFF81F, cap.imm);
    endtask
    task automatic t_regs;
        op(32'h00000013, 0, 0, 1, 5'h1F, 32'h12345678);
        op(32'h00000013, 0, 0, 1, 5'h00, 32'hDEADBEEF);
        op(32'h000F8033, 0, 0, 0, 0, 0);
        chk("opnd_a", 32'h12345678, cap.opnd_a);
        chk("opnd_b", 0, cap.opnd_b);
    endtask
    task automatic t_ctrl;
        op(32'h80000863, 0, 32'h00000102, 0, 0, 0);
        chk("imm_b", 32'hFFFFF010, cap.imm);
        chk("nt_exc", 0, xc.valid);
        chk("nt_pc", pc0 + `BID_INSTR_STEP, program_counter);
        op(32'h8020006F, 1, 32'h00000100, 0, 0, 0);
        chk("imm_j", 32'hFFF00002, cap.imm);
        chk("jmp_pc", 32'h00000100, program_counter);
        op(32'h000000EF, 1, 32'h00000102, 1, 5'h03, 32'h00000001);
        chk("mis_exc", 1, xc.valid);
        chk("mis_owner", pc0, xc.pc);
        chk("mis_target", 32'h00000102, xc.target);
        chk("mis_pc", `BID_TRAP_VEC, program_counter);
        chk("call", 1, cap.call_hint);
        op(32'h00018067, 0, 0, 0, 0, 0);
        chk("no_write", 0, cap.opnd_a);
        op(32'h00008067, 0, 0, 0, 0, 0);
        chk("ret", 1, cap.ret_hint);
    endtask
    task automatic t_sys;
        slow <= 1'b1;
        op(32'h00000073, 0, 0, 0, 0, 0);
        chk("env_call", 1, cap.sys_trap);
        op(32'h00100073, 0, 0, 0, 0, 0);
        chk("break", 1, cap.sys_trap);
        op(32'h0000000F, 0, 0, 0, 0, 0);
        chk("memory_a", 1, cap.memory_a_nop);
        op(32'h0000000B, 0, 0, 0, 0, 0);
        chk("reserved", 1, cap.illegal);
        op(32'h00000000, 0, 0, 0, 0, 0);
        chk("zero_word", 1, cap.illegal);
    endtask
    initial begin
        repeat (16) @(posedge clk_sys);
        srst <= 1'b0;
        step();
        chk("pc_rst", `BID_RESET_PC, program_counter);
        chk("iss_rst", 0, iss_valid);
        t_fields();
        t_regs();
        t_ctrl();
        t_sys();
        end_of_test();
    end
endmodule
